// file: core/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Register byte offsets
`define OFS_MODE      8'h00
`define OFS_CTRL      8'h04
`define OFS_T0_COUNT  8'h08
`define OFS_T1_COUNT  8'h0C
`define OFS_T2_COUNT  8'h10
`define OFS_T2_RELOAD 8'h14
`define OFS_IRQ_STAT  8'h18
`define OFS_IRQ_MASK  8'h1C

// timer_mode_reg fields
`define MODE_T0_LSB   0
`define MODE_T0_CT    2
`define MODE_T1_LSB   4
`define MODE_T1_CT    6

// timer2_control_reg fields
`define CTL_RUN0      0
`define CTL_RUN1      1
`define CTL_RUN2      2
`define CTL_CT2       3
`define CTL_T2M_LSB   4
`define CTL_TIMER2_EXT_ENABLE     6
`define CTL_RXSEL     7
`define CTL_TXSEL     8

// Status and mask bits
`define IRQ_T0        0
`define IRQ_T1        1
`define IRQ_T2        2
`define IRQ_EXT2      3

// Reset values
`define RST_MODE      8'h00
`define RST_CTRL      9'h000
`define RST_COUNT     16'h0000
`define RST_IRQ       4'h0

// Timing counts
`define PRESCALE_LAST 4'hB
`define BAUD_DIV_LAST 4'hF

`endif

// file: core/timer_pkg.sv
package timer_pkg;
  typedef logic [15:0] count_t;
  typedef enum logic [1:0]
  {
    T01_13BIT  = 2'b00,
    T01_16BIT  = 2'b01,
    T01_RELOAD = 2'b10,
    T01_SPLIT  = 2'b11
  } t01_mode_t;
  typedef enum logic [1:0]
  {
    T2_RELOAD  = 2'b00,
    T2_CAPTURE = 2'b01,
    T2_BAUD    = 2'b10,
    T2_SPARE   = 2'b11
  } t2_mode_t;
endpackage : timer_pkg

// file: core/pin_edge_sampler.sv
`timescale 1ns/1ps
module pin_edge_sampler
(
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       tick_in,
  input  wire logic [2:0] pin_in,
  output logic      [2:0] fall_out
);
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] level_q;
  logic [2:0] samp_q;
  logic [2:0] fall_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      sync3_q <= 3'h7;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Level accepted once two stages agree
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      level_q <= 3'h7;
    else
      level_q <= (sync2_q & sync3_q) | (level_q & (sync2_q ^ sync3_q));
  end

  // Sample only on the divide-by-12 tick
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      samp_q <= 3'h7;
      fall_q <= 3'h0;
    end
    else
    begin
      fall_q <= tick_in ? (samp_q & ~level_q) : 3'h0;
      if (tick_in)
        samp_q <= level_q;
    end
  end

  assign fall_out = fall_q;
endmodule : pin_edge_sampler

// file: core/three_timer_counter_unit.sv
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "timer_params.svh"
// Function
// - In timer mode each timer steps at most once per twelve clocks; Timer2 in baud mode steps every second clock.
// - In counter mode each timer steps on a falling edge of its pin.
// - A per-timer bit picks timer or counter mode: in timer_mode_reg for Timer0/Timer1, in timer2_control_reg for Timer2.
// - Timer0 and Timer1 run as 13-bit, 16-bit, 8-bit reload or mode 3.
// - In mode 3 Timer0 is two 8-bit counters owning Timer1's flag.
// - Timer2 offers auto-reload, capture and baud-rate modes.
// - Pins are sampled once per twelve clocks, so counts come 24 apart.
// - An overflow rolls the count to zero and sets the timer's flag; Timer2 sets no flag in baud mode, nor Timer1 while Timer0 is in mode 3.
// - In reload modes an overflow also reloads the count.
module three_timer_counter_unit
(
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        timer0_ext_input,
  input  wire logic        timer1_ext_input,
  input  wire logic        timer2_ext_input,
  output logic             rx_clock_tick_out,
  output logic             tx_clock_tick_out,
  output logic             irq_out
);
  import timer_pkg::*;

  logic [7:0]  timer_mode_reg_q;
  logic [8:0]  timer2_control_reg_q;
  count_t      t0_cnt_q;
  count_t      t1_cnt_q;
  count_t      t2_cnt_q;
  logic [7:0]  timer2_reload_high_q;
  logic [7:0]  timer2_reload_low_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_mask_q;
  logic [3:0]  pre_q;
  logic        tick12_q;
  logic        tick2_q;
  logic [3:0]  baud_div_q;
  logic        rx_tick_q;
  logic        tx_tick_q;
  logic        ack_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [2:0]  fall;
  logic        wr;
  t01_mode_t   m0;
  t01_mode_t   m1;
  t2_mode_t    m2;
  logic        run0;
  logic        run1;
  logic        run2;
  logic        timer2_ext_enable;
  logic        inc0;
  logic        inc1;
  logic        inc2;
  logic        inc0h;
  logic        ovf0;
  logic        ovf0h;
  logic        ovf1;
  logic        ovf2;
  logic        ext2;
  logic [16:0] nx0;
  logic [16:0] nx1;
  logic [3:0]  irq_set;
  count_t      reload2;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge

  // Next count and overflow for Timer0/Timer1 modes
  function automatic logic [16:0] step01(input t01_mode_t m,
                                         input count_t    c,
                                         input logic      en);
    logic [16:0] r;
    logic [13:0] t;
    r = {1'b0, c};
    t = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    if (en)
    begin
      case (m)
        T01_13BIT:  r = {t[13], t[12:5], c[7:5], t[4:0]};
        T01_16BIT:  r = {1'b0, c} + 17'h00001;
        T01_RELOAD: r = (c[7:0] == 8'hFF) ? {1'b1, c[15:8], c[15:8]}
                                          : {1'b0, c[15:8], c[7:0] + 8'h01};
        default:    r = {1'b0, c};
      endcase
    end
    return r;
  endfunction : step01

  function automatic logic hit(input logic [7:0] ofs);
    return wr && (wb_adr_in == ofs);
  endfunction : hit

  pin_edge_sampler u_pins
  (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tick12_q),
    .pin_in     ({timer2_ext_input, timer1_ext_input, timer0_ext_input}),
    .fall_out   (fall)
  );

  assign m0    = t01_mode_t'(timer_mode_reg_q[`MODE_T0_LSB +: 2]);
  assign m1    = t01_mode_t'(timer_mode_reg_q[`MODE_T1_LSB +: 2]);
  assign m2    = t2_mode_t'(timer2_control_reg_q[`CTL_T2M_LSB +: 2]);
  assign run0  = timer2_control_reg_q[`CTL_RUN0];
  assign run1  = timer2_control_reg_q[`CTL_RUN1];
  assign run2  = timer2_control_reg_q[`CTL_RUN2];
  assign timer2_ext_enable = timer2_control_reg_q[`CTL_TIMER2_EXT_ENABLE];
  assign reload2 = {timer2_reload_high_q, timer2_reload_low_q};

  // Clock/12 prescaler and clock/2 toggle
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      pre_q    <= 4'h0;
      tick12_q <= 1'b0;
      tick2_q  <= 1'b0;
    end
    else
    begin
      pre_q    <= (pre_q == `PRESCALE_LAST) ? 4'h0 : pre_q + 4'h1;
      tick12_q <= (pre_q == `PRESCALE_LAST);
      tick2_q  <= ~tick2_q;
    end
  end

  // Source select per timer
  assign inc0  = run0 && (timer_mode_reg_q[`MODE_T0_CT] ? fall[0]
                                                        : tick12_q);
  assign inc1  = run1 && (m1 != T01_SPLIT)
                 && (timer_mode_reg_q[`MODE_T1_CT] ? fall[1] : tick12_q);
  assign inc0h = run1 && tick12_q && (m0 == T01_SPLIT);
  assign inc2  = run2 && (timer2_control_reg_q[`CTL_CT2] ? fall[2]
                 : ((m2 == T2_BAUD) ? tick2_q : tick12_q));
  assign nx0   = step01(m0, t0_cnt_q, inc0);
  assign nx1   = step01(m1, t1_cnt_q, inc1);
  assign ovf0  = (m0 == T01_SPLIT) ? (inc0 && t0_cnt_q[7:0] == 8'hFF)
                                   : nx0[16];
  assign ovf0h = inc0h && (t0_cnt_q[15:8] == 8'hFF);
  assign ovf1  = nx1[16];
  assign ovf2  = inc2 && (t2_cnt_q == 16'hFFFF);
  assign ext2  = timer2_ext_enable && fall[2] && (m2 != T2_BAUD);

  // Timer0, split into two 8-bit halves in mode 3
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      t0_cnt_q <= `RST_COUNT;
    else if (hit(`OFS_T0_COUNT))
      t0_cnt_q <= count_t'(merge({16'h0000, t0_cnt_q}, wb_dat_in, wb_sel_in));
    else if (m0 == T01_SPLIT)
    begin
      if (inc0)
        t0_cnt_q[7:0] <= t0_cnt_q[7:0] + 8'h01;
      if (inc0h)
        t0_cnt_q[15:8] <= t0_cnt_q[15:8] + 8'h01;
    end
    else
      t0_cnt_q <= nx0[15:0];
  end

  // Timer1 holds in mode 3
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      t1_cnt_q <= `RST_COUNT;
    else if (hit(`OFS_T1_COUNT))
      t1_cnt_q <= count_t'(merge({16'h0000, t1_cnt_q}, wb_dat_in, wb_sel_in));
    else
      t1_cnt_q <= nx1[15:0];
  end

  // Timer2 count
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      t2_cnt_q <= `RST_COUNT;
    else if (hit(`OFS_T2_COUNT))
      t2_cnt_q <= count_t'(merge({16'h0000, t2_cnt_q}, wb_dat_in, wb_sel_in));
    else if (ovf2)
      t2_cnt_q <= (m2 == T2_CAPTURE) ? 16'h0000 : reload2;
    else if (ext2 && m2 == T2_RELOAD)
      t2_cnt_q <= reload2;
    else if (inc2)
      t2_cnt_q <= t2_cnt_q + 16'h0001;
  end

  // Timer2 reload/capture register; capture beats a bus write
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      {timer2_reload_high_q, timer2_reload_low_q} <= `RST_COUNT;
    else if (ext2 && m2 == T2_CAPTURE)
      {timer2_reload_high_q, timer2_reload_low_q} <= t2_cnt_q;
    else if (hit(`OFS_T2_RELOAD))
      {timer2_reload_high_q, timer2_reload_low_q} <=
        count_t'(merge({16'h0000, reload2}, wb_dat_in, wb_sel_in));
  end

  // Baud tick from overflow divided by 16
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      baud_div_q <= 4'h0;
      rx_tick_q  <= 1'b0;
      tx_tick_q  <= 1'b0;
    end
    else
    begin
      if (ovf2 && m2 == T2_BAUD)
        baud_div_q <= baud_div_q + 4'h1;
      rx_tick_q <= ovf2 && m2 == T2_BAUD && baud_div_q == `BAUD_DIV_LAST
                   && timer2_control_reg_q[`CTL_RXSEL];
      tx_tick_q <= ovf2 && m2 == T2_BAUD && baud_div_q == `BAUD_DIV_LAST
                   && timer2_control_reg_q[`CTL_TXSEL];
    end
  end

  // Sticky flags, set wins over write-one-to-clear
  assign irq_set[`IRQ_T0]   = ovf0;
  assign irq_set[`IRQ_T1]   = (m0 == T01_SPLIT) ? ovf0h : ovf1;
  assign irq_set[`IRQ_T2]   = ovf2 && (m2 != T2_BAUD);
  assign irq_set[`IRQ_EXT2] = ext2;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      irq_stat_q <= `RST_IRQ;
    else if (hit(`OFS_IRQ_STAT) && wb_sel_in[0])
      irq_stat_q <= (irq_stat_q & ~wb_dat_in[3:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  // Configuration registers
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      timer_mode_reg_q     <= `RST_MODE;
      timer2_control_reg_q <= `RST_CTRL;
      irq_mask_q           <= `RST_IRQ;
    end
    else
    begin
      if (hit(`OFS_MODE))
        timer_mode_reg_q <= 8'(merge({24'h000000, timer_mode_reg_q},
                                     wb_dat_in, wb_sel_in));
      if (hit(`OFS_CTRL))
        timer2_control_reg_q <= 9'(merge({23'h000000, timer2_control_reg_q},
                                         wb_dat_in, wb_sel_in));
      if (hit(`OFS_IRQ_MASK) && wb_sel_in[0])
        irq_mask_q <= wb_dat_in[3:0];
    end
  end

  // Wishbone slave: one wait state, ack for one cycle
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;

  always_comb
  begin
    rd_d = 32'h00000000;
    case (wb_adr_in)
      `OFS_MODE:      rd_d[7:0]  = timer_mode_reg_q;
      `OFS_CTRL:      rd_d[8:0]  = timer2_control_reg_q;
      `OFS_T0_COUNT:  rd_d[15:0] = t0_cnt_q;
      `OFS_T1_COUNT:  rd_d[15:0] = t1_cnt_q;
      `OFS_T2_COUNT:  rd_d[15:0] = t2_cnt_q;
      `OFS_T2_RELOAD: rd_d[15:0] = reload2;
      `OFS_IRQ_STAT:  rd_d[3:0]  = irq_stat_q;
      `OFS_IRQ_MASK:  rd_d[3:0]  = irq_mask_q;
      default:        rd_d       = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      ack_q <= 1'b0;
      rd_q  <= 32'h00000000;
    end
    else
    begin
      ack_q <= wb_cyc_in && wb_stb_in && !ack_q;
      rd_q  <= rd_d;
    end
  end

  assign wb_ack_out        = ack_q;
  assign wb_dat_out        = rd_q;
  assign rx_clock_tick_out = rx_tick_q;
  assign tx_clock_tick_out = tx_tick_q;
  assign irq_out           = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  tick_rate_a: assert property (
    (m0 == T01_16BIT && !timer_mode_reg_q[`MODE_T0_CT] && !tick12_q
     && !hit(`OFS_T0_COUNT)) |=> $stable(t0_cnt_q))
    else $error("timer0 stepped off the clock/12 tick");
  pin_count_a: assert property (
    (m1 == T01_16BIT && timer_mode_reg_q[`MODE_T1_CT] && run1 && fall[1]
     && t1_cnt_q != 16'hFFFF && !hit(`OFS_T1_COUNT))
    |=> t1_cnt_q == $past(t1_cnt_q) + 16'h0001)
    else $error("timer1 missed a pin falling edge");
  ct_select_a: assert property (
    (m0 == T01_16BIT && timer_mode_reg_q[`MODE_T0_CT] && !fall[0]
     && !hit(`OFS_T0_COUNT)) |=> $stable(t0_cnt_q))
    else $error("timer0 counter mode stepped without a pin edge");
  wrap13_a: assert property (
    (m0 == T01_13BIT && inc0 && t0_cnt_q[15:8] == 8'hFF
     && t0_cnt_q[4:0] == 5'h1F && !hit(`OFS_T0_COUNT))
    |=> t0_cnt_q[15:8] == 8'h00 && t0_cnt_q[4:0] == 5'h00
        && irq_stat_q[`IRQ_T0])
    else $error("13-bit wrap wrong");
  t1_hold_a: assert property (
    (m1 == T01_SPLIT && !hit(`OFS_T1_COUNT)) |=> $stable(t1_cnt_q))
    else $error("timer1 moved in mode 3");
  split_irq_a: assert property (
    (m0 == T01_SPLIT && inc0h && t0_cnt_q[15:8] == 8'hFF)
    |=> irq_stat_q[`IRQ_T1])
    else $error("timer0 high half did not raise timer1 flag");
  capture_a: assert property (
    (m2 == T2_CAPTURE && ext2) |=> reload2 == $past(t2_cnt_q))
    else $error("timer2 capture lost");
  pin_spacing_a: assert property (
    fall[2] |-> $past(tick12_q) ##1 (!fall[2])[*8])
    else $error("pin edges closer than the sampling rate");
  wrap16_a: assert property (
    (m1 == T01_16BIT && m0 != T01_SPLIT && inc1 && t1_cnt_q == 16'hFFFF
     && !hit(`OFS_T1_COUNT))
    |=> t1_cnt_q == 16'h0000 && irq_stat_q[`IRQ_T1])
    else $error("timer1 16-bit overflow wrong");
  reload8_a: assert property (
    (m0 == T01_RELOAD && inc0 && t0_cnt_q[7:0] == 8'hFF
     && !hit(`OFS_T0_COUNT))
    |=> t0_cnt_q[7:0] == t0_cnt_q[15:8] && irq_stat_q[`IRQ_T0])
    else $error("8-bit reload wrong");
  baud_reload_a: assert property (
    (m2 == T2_BAUD && ovf2 && !hit(`OFS_T2_COUNT)
     && !hit(`OFS_T2_RELOAD)) |=> t2_cnt_q == reload2)
    else $error("baud mode did not reload");
  ext_flag_a: assert property (
    ext2 |=> irq_stat_q[`IRQ_EXT2])
    else $error("timer2 external flag not set");
endmodule : three_timer_counter_unit

// file: tb/count_pin_source.sv
`timescale 1ns/1ps
module count_pin_source
(
  input  wire logic       ref_clk_in,
  input  wire logic       start_in,
  input  wire logic [3:0] pulses_in,
  input  wire logic [7:0] hold_in,
  output logic      [2:0] pin_out = 3'h7
);
  int left = 0;
  int cnt  = 0;
  // Each level held hold_in clocks, idle high between bursts
  always @(posedge ref_clk_in)
  begin
    if (start_in && left == 0)
    begin
      left <= 2 * pulses_in;
      cnt  <= 0;
    end
    else if (left > 0 && cnt + 1 >= hold_in)
    begin
      pin_out <= ~pin_out;
      left    <= left - 1;
      cnt     <= 0;
    end
    else if (left > 0)
      cnt <= cnt + 1;
  end
endmodule : count_pin_source

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "timer_params.svh"
module tb_top;
  logic        ref_clk_in;
  logic        sys_rst_in;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [3:0]  lanes;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  pin;
  logic        rx_tick;
  logic        tx_tick;
  logic        irq;
  logic        start;
  logic [3:0]  pulses;
  logic [31:0] d;
  int          failures;
  int          samples_checked;
  int          n;
  logic [15:0] starts [3];
  logic [7:0]  highs  [3];

  three_timer_counter_unit i_dut
  (
    .ref_clk_in        (ref_clk_in),
    .sys_rst_in        (sys_rst_in),
    .wb_cyc_in         (cyc),
    .wb_stb_in         (stb),
    .wb_we_in          (we),
    .wb_adr_in         (adr),
    .wb_sel_in         (sel),
    .wb_dat_in         (wdat),
    .wb_dat_out        (rdat),
    .wb_ack_out        (ack),
    .timer0_ext_input  (pin[0]),
    .timer1_ext_input  (pin[1]),
    .timer2_ext_input  (pin[2]),
    .rx_clock_tick_out (rx_tick),
    .tx_clock_tick_out (tx_tick),
    .irq_out           (irq)
  );

  count_pin_source i_pins
  (
    .ref_clk_in (ref_clk_in),
    .start_in   (start),
    .pulses_in  (pulses),
    .hold_in    (8'h0C),
    .pin_out    (pin)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic tally_and_finish;
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge ref_clk_in);
    chk({31'h0, ack}, 32'h0);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= lanes;
    wdat <= v;
    do
      @(posedge ref_clk_in);
    while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(d & m, e);
  endtask : rd

  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(posedge ref_clk_in);
      k++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask : wait_irq

  task automatic burst(input logic [3:0] p);
    @(posedge ref_clk_in);
    start  <= 1'b1;
    pulses <= p;
    @(posedge ref_clk_in);
    start  <= 1'b0;
  endtask : burst

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    failures = 0;
    samples_checked = 0;
    sys_rst_in = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    lanes = 4'hF;
    wdat = 32'h0;
    start = 1'b0;
    pulses = 4'h0;
    starts = '{16'hFF1F, 16'hFFFF, 16'hFFFF};
    highs = '{8'h00, 8'h00, 8'hFF};
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    wr(8'h20, 32'hFFFFFFFF);
    for (int a = 0; a <= 32; a += 4)
      rd(a[7:0], 32'hFFFFFFFF, 32'h0);
    wr(`OFS_MODE, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    repeat (120) @(posedge ref_clk_in);
    wr(`OFS_CTRL, 32'h0);
    bus(1'b0, `OFS_T0_COUNT, 32'h0);
    chk({31'h0, d >= 10 && d <= 11}, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFS_MODE, i);
      wr(`OFS_T0_COUNT, {16'h0, starts[i]});
      wr(`OFS_IRQ_MASK, 32'h1);
      wr(`OFS_CTRL, 32'h1);
      wait_irq(40);
      wr(`OFS_CTRL, 32'h0);
      rd(`OFS_T0_COUNT, 32'hFF00, {16'h0, highs[i], 8'h0});
      rd(`OFS_IRQ_STAT, 32'hF, 32'h1);
      wr(`OFS_IRQ_MASK, 32'h0);
      @(posedge ref_clk_in);
      chk({31'h0, irq}, 32'h0);
      wr(`OFS_IRQ_STAT, 32'hF);
      rd(`OFS_IRQ_STAT, 32'hF, 32'h0);
    end
    wr(`OFS_MODE, 32'h33);
    wr(`OFS_T0_COUNT, 32'hFF00);
    wr(`OFS_T1_COUNT, 32'h1234);
    wr(`OFS_IRQ_MASK, 32'h2);
    wr(`OFS_CTRL, 32'h2);
    wait_irq(40);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_IRQ_STAT, 32'hF, 32'h2);
    rd(`OFS_T1_COUNT, 32'hFFFF, 32'h1234);
    rd(`OFS_T0_COUNT, 32'hFF, 32'h0);
    wr(`OFS_IRQ_STAT, 32'hF);
    wr(`OFS_MODE, 32'h55);
    for (int a = 8; a <= 16; a += 4)
      wr(a[7:0], 32'h0);
    wr(`OFS_CTRL, 32'hF);
    burst(4'h3);
    repeat (110) @(posedge ref_clk_in);
    wr(`OFS_CTRL, 32'h0);
    for (int a = 8; a <= 16; a += 4)
      rd(a[7:0], 32'hFFFF, 32'h3);
    wr(`OFS_T2_COUNT, 32'h0100);
    wr(`OFS_IRQ_MASK, 32'h8);
    wr(`OFS_CTRL, 32'h54);
    burst(4'h1);
    wait_irq(80);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_IRQ_STAT, 32'h8, 32'h8);
    rd(`OFS_T2_RELOAD, 32'hFF00, 32'h0100);
    wr(`OFS_IRQ_STAT, 32'hF);
    lanes = 4'h1;
    wr(`OFS_T2_RELOAD, 32'h5A5A);
    lanes = 4'hF;
    rd(`OFS_T2_RELOAD, 32'hFFFF, 32'h015A);
    wr(`OFS_T2_RELOAD, 32'hABCD);
    wr(`OFS_T2_COUNT, 32'hFFFF);
    wr(`OFS_IRQ_MASK, 32'h4);
    wr(`OFS_CTRL, 32'h4);
    wait_irq(40);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_T2_COUNT, 32'hFF00, 32'hAB00);
    rd(`OFS_IRQ_STAT, 32'hF, 32'h4);
    wr(`OFS_IRQ_STAT, 32'hF);
    wr(`OFS_IRQ_MASK, 32'hF);
    wr(`OFS_T2_RELOAD, 32'hFFFE);
    wr(`OFS_T2_COUNT, 32'hFFFE);
    wr(`OFS_CTRL, 32'h1A4);
    n = 0;
    while (rx_tick !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    @(posedge ref_clk_in);
    n = 1;
    while (rx_tick !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(n, 32'h40);
    chk({31'h0, tx_tick}, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_IRQ_STAT, 32'hF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_T2_RELOAD, 32'h1200);
    wr(`OFS_T2_COUNT, 32'h0);
    wr(`OFS_CTRL, 32'h44);
    burst(4'h1);
    wait_irq(80);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_T2_COUNT, 32'hFF00, 32'h1200);
    rd(`OFS_IRQ_STAT, 32'hF, 32'h8);
    tally_and_finish();
  end
endmodule : tb_top
